// >>> rtl/dgc_chan.sv
`timescale 1ns/1ns
`default_nettype none
// One channel: code hold latch plus pulse-mode step counter
module dgc_chan (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_par_mode,
    input  wire logic       i_pulse_mode,
    input  wire logic       i_enable,
    input  wire logic [5:0] i_gain_code,
    input  wire logic       i_gain_hold,
    input  wire logic       i_step_up_n,
    input  wire logic       i_step_down_n,
    input  wire logic [1:0] i_step_size,
    output logic      [5:0] o_atten,
    output logic            o_active
);
    logic [5:0] atten_r;
    logic [5:0] atten_nxt;
    logic       up_q_r;
    logic       dn_q_r;
    logic       act_r;
    wire        up_rise = i_step_up_n & ~up_q_r;
    wire        dn_rise = i_step_down_n & ~dn_q_r;
    wire        both_lo = ~up_q_r & ~dn_q_r;
    wire [5:0]  step =
        (i_step_size == 2'b00) ? dgc_pkg::STEP_0P5DB :
        (i_step_size == 2'b01) ? dgc_pkg::STEP_1DB :
        (i_step_size == 2'b10) ? dgc_pkg::STEP_2DB : dgc_pkg::STEP_6DB;
    wire [6:0]  dn_sum = {1'b0, atten_r} + {1'b0, step};
    wire [5:0]  dn_val = dn_sum[6] ? dgc_pkg::CODE_MIN_GAIN : dn_sum[5:0];
    wire [5:0]  up_val = (atten_r < step) ? dgc_pkg::CODE_MAX_GAIN : atten_r - step;

    always_comb begin
        atten_nxt = atten_r;
        if (i_par_mode && !i_gain_hold) begin
            atten_nxt = i_gain_code;
        end else if (i_pulse_mode) begin
            if (up_rise && dn_rise) begin
                atten_nxt = dgc_pkg::CODE_MAX_GAIN;
            end else if (both_lo && (up_rise || dn_rise)) begin
                atten_nxt = dgc_pkg::CODE_MAX_GAIN;
            end else if (up_rise) begin
                atten_nxt = up_val;
            end else if (dn_rise) begin
                atten_nxt = dn_val;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            atten_r <= dgc_pkg::CODE_MAX_GAIN;
            up_q_r  <= 1'b1;
            dn_q_r  <= 1'b1;
            act_r   <= 1'b0;
        end else begin
            atten_r <= atten_nxt;
            up_q_r  <= i_step_up_n;
            dn_q_r  <= i_step_down_n;
            act_r   <= i_enable;
        end
    end

    assign o_atten  = atten_r;
    assign o_active = act_r;
endmodule // dgc_chan
`default_nettype wire

// >>> rtl/dgc_pkg.sv
package dgc_pkg;
    localparam int CODE_W = 6;
    localparam logic [5:0] CODE_MAX_GAIN = 6'h00;
    localparam logic [5:0] CODE_MIN_GAIN = 6'h3F;
    // Attenuation code counts in half-dB units
    localparam logic [5:0] STEP_0P5DB = 6'h01;
    localparam logic [5:0] STEP_1DB   = 6'h02;
    localparam logic [5:0] STEP_2DB   = 6'h04;
    localparam logic [5:0] STEP_6DB   = 6'h0C;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SDO_RELEASE_NS = 50;
    localparam int SDO_VALID_NS = 20;
    // Longest times round down, never below one cycle
    localparam int SDO_RELEASE_CYC = (SDO_RELEASE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                     (SDO_RELEASE_NS / CLK_PERIOD_NS);
    localparam int SDO_VALID_CYC = (SDO_VALID_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                   (SDO_VALID_NS / CLK_PERIOD_NS);
    typedef enum logic [1:0] {
        DGC_MODE_SERIAL   = 2'b10,
        DGC_MODE_PULSE    = 2'b01,
        DGC_MODE_PARALLEL = 2'b11,
        DGC_MODE_NONE     = 2'b00
    } dgc_mode_e;
endpackage

// >>> rtl/dgc_top.sv
// Operation
// - Open mode inputs read high, giving parallel mode.
// - Both mode inputs high selects parallel mode from dedicated code inputs.
// - Six-bit attenuation code, bit weights 0.5 to 16 dB, zero is maximum gain.
// - Hold low follows code inputs; hold high keeps last gain.
// - Each channel's active output follows its own enable; the gain code updates whatever the enable.
// - Serial data output released within 50 ns of chip select rising.
// - Serial data output updates on falling serial clock, valid within 20 ns.
// - Low pulse on up raises gain one step; on down lowers it.
// - Pulsing up and down together resets gain to maximum.
// - Step size inputs pick 0.5, 1, 2 or 6 dB.
`timescale 1ns/1ns
`default_nettype none
module dgc_top (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_mode_select_lo_n_open,
    input  wire logic       i_mode_select_lo,
    input  wire logic       i_mode_select_hi_n_open,
    input  wire logic       i_mode_select_hi,
    input  wire logic       i_chan_a_enable,
    input  wire logic       i_chan_b_enable,
    input  wire logic [5:0] i_chan_a_gain,
    input  wire logic [5:0] i_chan_b_gain,
    input  wire logic       i_chan_a_gain_hold,
    input  wire logic       i_chan_b_gain_hold,
    input  wire logic       i_chan_a_step_up,
    input  wire logic       i_chan_b_step_up,
    input  wire logic       i_chan_a_step_down,
    input  wire logic       i_chan_b_step_down,
    input  wire logic       i_chan_a_step_size_lo,
    input  wire logic       i_chan_a_step_size_hi,
    input  wire logic       i_chan_b_step_size_lo,
    input  wire logic       i_chan_b_step_size_hi,
    input  wire logic       i_ser_cs,
    input  wire logic       i_ser_clk,
    output logic            o_ser_sdo,
    output logic            o_ser_sdo_oe,
    output logic      [5:0] o_chan_a_atten,
    output logic      [5:0] o_chan_b_atten,
    output logic            o_chan_a_active,
    output logic            o_chan_b_active,
    output logic      [1:0] o_mode
);
    wire mode_lo = i_mode_select_lo | ~i_mode_select_lo_n_open;
    wire mode_hi = i_mode_select_hi | ~i_mode_select_hi_n_open;
    dgc_pkg::dgc_mode_e mode;
    assign mode = dgc_pkg::dgc_mode_e'({mode_hi, mode_lo});
    wire par_mode   = (mode == dgc_pkg::DGC_MODE_PARALLEL);
    wire pulse_mode = (mode == dgc_pkg::DGC_MODE_PULSE);
    wire ser_mode   = (mode == dgc_pkg::DGC_MODE_SERIAL);

    logic [5:0] atten_a;
    logic [5:0] atten_b;
    logic       act_a;
    logic       act_b;

    dgc_chan u_chan_a (
        .i_mclk        (i_mclk),
        .i_rst         (i_rst),
        .i_par_mode    (par_mode),
        .i_pulse_mode  (pulse_mode),
        .i_enable      (i_chan_a_enable),
        .i_gain_code   (i_chan_a_gain),
        .i_gain_hold   (i_chan_a_gain_hold),
        .i_step_up_n   (i_chan_a_step_up),
        .i_step_down_n (i_chan_a_step_down),
        .i_step_size   ({i_chan_a_step_size_hi, i_chan_a_step_size_lo}),
        .o_atten       (atten_a),
        .o_active      (act_a)
    );
    dgc_chan u_chan_b (
        .i_mclk        (i_mclk),
        .i_rst         (i_rst),
        .i_par_mode    (par_mode),
        .i_pulse_mode  (pulse_mode),
        .i_enable      (i_chan_b_enable),
        .i_gain_code   (i_chan_b_gain),
        .i_gain_hold   (i_chan_b_gain_hold),
        .i_step_up_n   (i_chan_b_step_up),
        .i_step_down_n (i_chan_b_step_down),
        .i_step_size   ({i_chan_b_step_size_hi, i_chan_b_step_size_lo}),
        .o_atten       (atten_b),
        .o_active      (act_b)
    );

    // Serial readback: shifts the A then B codes out, MSB first
    logic        sclk_q_r;
    logic        cs_q_r;
    logic [11:0] shift_r;
    logic        sdo_r;
    logic        oe_r;
    wire         sclk_fall = sclk_q_r & ~i_ser_clk;
    wire         cs_fall   = cs_q_r & ~i_ser_cs;
    wire         cs_rise   = ~cs_q_r & i_ser_cs;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sclk_q_r <= 1'b0;
            cs_q_r   <= 1'b1;
            shift_r  <= 12'h000;
            sdo_r    <= 1'b0;
            oe_r     <= 1'b0;
        end else begin
            sclk_q_r <= i_ser_clk;
            cs_q_r   <= i_ser_cs;
            if (cs_fall) begin
                shift_r <= {atten_a, atten_b};
            end else if (ser_mode && !i_ser_cs && sclk_fall) begin
                sdo_r   <= shift_r[11];
                shift_r <= {shift_r[10:0], 1'b0};
                oe_r    <= 1'b1;
            end
            if (cs_rise || !ser_mode) begin
                oe_r <= 1'b0;
            end
        end
    end

    logic [5:0] out_a_r;
    logic [5:0] out_b_r;
    logic       out_act_a_r;
    logic       out_act_b_r;
    logic [1:0] mode_r;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            out_a_r     <= 6'h00;
            out_b_r     <= 6'h00;
            out_act_a_r <= 1'b0;
            out_act_b_r <= 1'b0;
            mode_r      <= 2'h3;
        end else begin
            out_a_r     <= atten_a;
            out_b_r     <= atten_b;
            out_act_a_r <= act_a;
            out_act_b_r <= act_b;
            mode_r      <= mode;
        end
    end

    assign o_ser_sdo       = sdo_r;
    assign o_ser_sdo_oe    = oe_r;
    assign o_chan_a_atten  = out_a_r;
    assign o_chan_b_atten  = out_b_r;
    assign o_chan_a_active = out_act_a_r;
    assign o_chan_b_active = out_act_b_r;
    assign o_mode          = mode_r;
endmodule // dgc_top
`default_nettype wire

// >>> sim/dgc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module dgc_monitor (
    input wire logic       i_mclk,
    input wire logic       i_rst,
    input wire logic       i_mode_select_lo_n_open,
    input wire logic       i_mode_select_hi_n_open,
    input wire logic [5:0] i_chan_a_gain,
    input wire logic       i_chan_a_gain_hold,
    input wire logic       i_chan_a_enable,
    input wire logic       i_chan_a_step_up,
    input wire logic       i_chan_a_step_down,
    input wire logic       i_ser_cs,
    input wire logic       i_ser_clk,
    input wire logic       o_ser_sdo_oe,
    input wire logic [5:0] o_chan_a_atten,
    input wire logic       o_chan_a_active,
    input wire logic [1:0] o_mode
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence both_s;
        o_mode == 2'b01 && !i_chan_a_step_up && !i_chan_a_step_down ##1 i_chan_a_step_up;
    endsequence
    sequence down_s;
        o_mode == 2'b01 && i_chan_a_step_up && !i_chan_a_step_down ##1 i_chan_a_step_down;
    endsequence
    code_follow_a: assert property (
        (o_mode == 2'b11 && !i_chan_a_gain_hold)[*3] |-> o_chan_a_atten == $past(i_chan_a_gain, 2))
        else $error("code not followed");
    gain_hold_a: assert property (
        (o_mode == 2'b11 && i_chan_a_gain_hold)[*3] |-> $stable(o_chan_a_atten))
        else $error("held code moved");
    enable_follow_a: assert property (
        $changed(i_chan_a_enable) ##1 $stable(i_chan_a_enable)
        |-> ##[0:1] o_chan_a_active == i_chan_a_enable) else $error("enable lost");
    open_parallel_a: assert property (
        (!i_mode_select_lo_n_open && !i_mode_select_hi_n_open)[*2] |-> o_mode == 2'b11)
        else $error("open pins not parallel");
    sdo_release_a: assert property ($rose(i_ser_cs) |-> ##[1:5] !o_ser_sdo_oe)
        else $error("sdo not released");
    sdo_drive_a: assert property (
        o_mode == 2'b10 && !i_ser_cs && $fell(i_ser_clk) |-> ##[1:2] o_ser_sdo_oe)
        else $error("sdo not driven");
    step_reset_a: assert property (both_s |-> ##[1:3] o_chan_a_atten == 6'h00)
        else $error("no reset to max gain");
    step_down_a: assert property (down_s |-> ##[1:3] o_chan_a_atten != 6'h00)
        else $error("down step missing");
endmodule // dgc_monitor
bind dgc_top dgc_monitor i_dgc_monitor (.*);
`default_nettype wire

// >>> sim/dgc_pulser.sv
`timescale 1ns/1ns
`default_nettype none
// Controller side: active-low step pulses, one request per i_req strobe
module dgc_pulser (
    input  wire logic       i_mclk,
    input  wire logic [1:0] i_req,
    output logic            o_up_n,
    output logic            o_dn_n
);
    logic [2:0] cnt_r = 3'h0;
    logic [1:0] req_r = 2'h0;
    always_ff @(posedge i_mclk) begin
        if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
        end else if (i_req != 2'h0) begin
            cnt_r <= 3'h3;
            req_r <= i_req;
        end
    end
    assign o_up_n = !(cnt_r != 3'h0 && req_r[1]);
    assign o_dn_n = !(cnt_r != 3'h0 && req_r[0]);
endmodule // dgc_pulser
`default_nettype wire

// >>> sim/test_dgc_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_dgc_top;
    logic       i_mclk = 1'b0, i_rst = 1'b1, i_ser_cs = 1'b1, i_ser_clk = 1'b0;
    logic       i_mode_select_lo_n_open = 1'b1, i_mode_select_hi_n_open = 1'b1;
    logic       i_mode_select_lo = 1'b1, i_mode_select_hi = 1'b1;
    logic       i_chan_a_enable = 1'b1, i_chan_b_enable = 1'b1;
    logic       i_chan_a_gain_hold = 1'b0, i_chan_b_gain_hold = 1'b0;
    logic [5:0] i_chan_a_gain = 6'h00, i_chan_b_gain = 6'h00, exp_a, exp_b;
    logic [1:0] sz = 2'h0, req = 2'h0;
    wire logic  i_chan_a_step_up, i_chan_a_step_down, i_chan_b_step_up, i_chan_b_step_down;
    wire logic  i_chan_a_step_size_lo = sz[0], i_chan_a_step_size_hi = sz[1];
    wire logic  i_chan_b_step_size_lo = ~sz[0], i_chan_b_step_size_hi = ~sz[1];
    logic       o_ser_sdo, o_ser_sdo_oe, o_chan_a_active, o_chan_b_active;
    logic [5:0] o_chan_a_atten, o_chan_b_atten;
    logic [1:0] o_mode;
    logic [11:0] ser_word;
    int         failures = 0, num_checks = 0;
    always #5 i_mclk = ~i_mclk;
    dgc_top i_dgc_top (.*);
    dgc_pulser i_dgc_pulser_a (
        .i_mclk (i_mclk),
        .i_req  (req),
        .o_up_n (i_chan_a_step_up),
        .o_dn_n (i_chan_a_step_down)
    );
    dgc_pulser i_dgc_pulser_b (
        .i_mclk (i_mclk),
        .i_req  (req),
        .o_up_n (i_chan_b_step_up),
        .o_dn_n (i_chan_b_step_down)
    );
    function automatic logic [5:0] step(input logic [1:0] s);
        return (s == 2'h3) ? 6'h0C : (6'h01 << s);
    endfunction
    task automatic check(input logic [5:0] seen, input logic [5:0] expv);
        num_checks++;
        if (seen !== expv) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic results;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Returns just after the last edge so outputs launched there have settled
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // Pulse gap left long so the step lands before the next request
    task automatic pulse(input logic [1:0] r);
        @(posedge i_mclk) req <= r;
        @(posedge i_mclk) req <= 2'h0;
        tick(8);
    endtask
    initial begin
        tick(15);
        @(posedge i_mclk) i_rst <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            @(posedge i_mclk) i_chan_a_gain <= 6'h01 << k;
            i_chan_b_gain <= ~(6'h01 << k);
            tick(3);
            check(o_chan_a_atten, 6'h01 << k);
            check(o_chan_b_atten, ~(6'h01 << k));
        end
        $display("parallel codes done");
        @(posedge i_mclk) i_chan_a_gain_hold <= 1'b1;
        tick(2);
        @(posedge i_mclk) i_chan_a_gain <= 6'h2A;
        tick(4);
        check(o_chan_a_atten, 6'h20);
        @(posedge i_mclk) i_chan_a_gain_hold <= 1'b0;
        tick(4);
        check(o_chan_a_atten, 6'h2A);
        @(posedge i_mclk) i_chan_a_enable <= 1'b0;
        tick(4);
        check({4'h0, o_chan_a_active, o_chan_b_active}, 6'h01);
        @(posedge i_mclk) i_chan_a_enable <= 1'b1;
        i_chan_b_enable <= 1'b0;
        tick(4);
        check({4'h0, o_chan_a_active, o_chan_b_active}, 6'h02);
        $display("hold and enable done");
        for (int m = 0; m < 4; m++) begin
            @(posedge i_mclk) i_mode_select_lo <= m[0];
            i_mode_select_hi <= m[1];
            tick(3);
            check({4'h0, o_mode}, m[5:0]);
        end
        @(posedge i_mclk) i_mode_select_lo <= 1'b0;
        i_mode_select_hi <= 1'b0;
        i_mode_select_lo_n_open <= 1'b0;
        tick(3);
        check({4'h0, o_mode}, 6'h01);
        @(posedge i_mclk) i_mode_select_hi_n_open <= 1'b0;
        tick(3);
        check({4'h0, o_mode}, 6'h03);
        $display("modes done");
        @(posedge i_mclk) i_mode_select_lo_n_open <= 1'b1;
        i_mode_select_lo <= 1'b1;
        i_mode_select_hi_n_open <= 1'b1;
        tick(4);
        pulse(2'b11);
        check(o_chan_a_atten, 6'h00);
        check(o_chan_b_atten, 6'h00);
        pulse(2'b10);
        check(o_chan_a_atten, 6'h00);
        exp_a = 6'h00;
        exp_b = 6'h00;
        for (int s = 0; s < 5; s++) begin
            @(posedge i_mclk) sz <= s[1:0];
            pulse((s == 4) ? 2'b10 : 2'b01);
            exp_a = (s == 4) ? exp_a - step(s[1:0]) : exp_a + step(s[1:0]);
            exp_b = (s == 4) ? exp_b - step(~s[1:0]) : exp_b + step(~s[1:0]);
            check(o_chan_a_atten, exp_a);
            check(o_chan_b_atten, exp_b);
        end
        $display("pulse mode done");
        @(posedge i_mclk) i_mode_select_hi_n_open <= 1'b1;
        i_mode_select_hi <= 1'b1;
        i_mode_select_lo <= 1'b0;
        ser_word = {exp_a, exp_b};
        tick(4);
        @(posedge i_mclk) i_ser_cs <= 1'b0;
        // serial clock 10 MHz, even duty
        for (int n = 11; n >= 0; n--) begin
            @(posedge i_mclk) i_ser_clk <= 1'b1;
            tick(4);
            @(posedge i_mclk) i_ser_clk <= 1'b0;
            tick(4);
            check({4'h0, o_ser_sdo_oe, o_ser_sdo}, {4'h0, 1'b1, ser_word[n]});
        end
        @(posedge i_mclk) i_ser_cs <= 1'b1;
        tick(5);
        check({5'h00, o_ser_sdo_oe}, 6'h00);
        // idle gap of three serial periods
        tick(30);
        $display("serial done");
        results();
    end
endmodule // test_dgc_top
`default_nettype wire
